/* rtl/swif_top.sv */
// Design decisions made here: the Wishbone register port and the register offsets.
`include "swif_defs.svh"
module swif_top #(
  parameter int OST_CYCLES = `SWIF_OST_PERIODS,
  parameter int LP_CYCLES = `SWIF_LP_SETTLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] evt1_i,
  input wire logic [7:0] evt2_i,
  input wire logic [7:0] evt3_i,
  input wire logic ext_irq_i,
  input wire logic wdt_timeout_i,
  input wire logic sleep_exec_i,
  input wire logic osc_tick_i,
  output logic cpu_clk_en_o,
  output logic wdt_clear_o,
  output logic sleep_active_o,
  output logic regulator_lp_o,
  output logic resume_o,
  output logic vector_isr_o,
  output logic sleep_nop_o,
  output logic power_down_status_o,
  output logic timeout_status_o
);
  // peripheral events come from other logic on this clock, no sync needed
  logic [7:0] flags1_q, flags2_q, flags3_q, intctl_q, ena1_q, ena2_q, ena3_q;
  logic [7:0] pwrctl_q, option_q;
  logic pd_q, to_q;
  swif_pkg::swif_state_t state_q, state_d;
  logic [10:0] wait_q, wait_d;
  logic [31:0] dat_q;
  logic ack_q;
  swif_pkg::swif_ctl_t ctl_q, ctl_d;
  logic resume_q, nop_q, sleep_q;

  // wishbone decode; a write lands at the edge that sees ack, as the master expects
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
  wire [7:0] wdat = wb_dat_i[7:0];
  wire wr1 = wr & (wb_adr_i == 8'(`SWIF_OFF_FLAGS1));
  wire wr2 = wr & (wb_adr_i == 8'(`SWIF_OFF_FLAGS2));
  wire wr3 = wr & (wb_adr_i == 8'(`SWIF_OFF_FLAGS3));
  wire wric = wr & (wb_adr_i == 8'(`SWIF_OFF_INTCTL));
  wire wre1 = wr & (wb_adr_i == 8'(`SWIF_OFF_ENA1));
  wire wre2 = wr & (wb_adr_i == 8'(`SWIF_OFF_ENA2));
  wire wre3 = wr & (wb_adr_i == 8'(`SWIF_OFF_ENA3));
  wire wrpc = wr & (wb_adr_i == 8'(`SWIF_OFF_PWRCTL));
  wire wrop = wr & (wb_adr_i == 8'(`SWIF_OFF_OPTION));

  // flag update: a software write keeps read-only bits, events win over clears
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] evt,
                                           input logic we, input logic [7:0] wv,
                                           input logic [7:0] ro, input logic [7:0] msk);
    logic [7:0] base;
    base = we ? ((wv & ~ro) | (cur & ro)) : cur;
    flag_next = (base | evt) & msk;
  endfunction

  wire [7:0] flags1_d = flag_next(flags1_q, evt1_i, wr1, wdat, `SWIF_SW_RO1, `SWIF_MASK1);
  wire [7:0] flags2_d = flag_next(flags2_q, evt2_i, wr2, wdat, 8'h00, `SWIF_MASK2);
  wire [7:0] flags3_d = flag_next(flags3_q, evt3_i, wr3, wdat, 8'h00, `SWIF_MASK3);

  wire periph_req = intctl_q[`SWIF_BIT_PERIPHERAL_IRQ_ENABLE] &
                    (|(flags1_q & ena1_q) | |(flags2_q & ena2_q) | |(flags3_q & ena3_q));
  // global enable not needed to wake
  wire wake_req = periph_req | ext_irq_i;
  wire global_irq_enable = intctl_q[`SWIF_BIT_GIE];
  wire xtal = pwrctl_q[`SWIF_BIT_XTAL] & ~pwrctl_q[`SWIF_BIT_TWOSPD];
  wire lp = pwrctl_q[`SWIF_BIT_REGULATOR_POWER_MODE_SEL];
  // wake delay depends on oscillator and regulator mode
  wire [10:0] wake_len = xtal ? 11'(OST_CYCLES) : (lp ? 11'(LP_CYCLES) : 11'h000);
  wire enter = (state_q == swif_pkg::ST_AWAKE) & sleep_exec_i;

  // sleep sequencer
  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    ctl_d = ctl_q;
    ctl_d.clear_wdt = 1'b0;
    ctl_d.vector_isr = 1'b0;
    case (state_q)
      swif_pkg::ST_AWAKE: begin
        // pending interrupt turns sleep into a no-op while global enable is clear
        if (sleep_exec_i && !(wake_req && !global_irq_enable)) begin
          state_d = swif_pkg::ST_SLEEP;
          ctl_d.clear_wdt = 1'b1;
          ctl_d.cpu_clk_en = 1'b0;
          ctl_d.regulator_lp = lp;
        end
      end
      swif_pkg::ST_SLEEP: begin
        // late interrupt or watchdog wakes at once
        if (wake_req || wdt_timeout_i) begin
          ctl_d.clear_wdt = 1'b1;
          ctl_d.regulator_lp = 1'b0;
          wait_d = wake_len;
          state_d = swif_pkg::ST_WAKE_WAIT;
        end
      end
      swif_pkg::ST_WAKE_WAIT: begin
        // watchdog held clear until start-up ends
        ctl_d.clear_wdt = 1'b1;
        if (wait_q == 11'h000) begin
          // run prefetched word, then vector if enabled
          ctl_d.cpu_clk_en = 1'b1;
          ctl_d.vector_isr = global_irq_enable & wake_req;
          state_d = swif_pkg::ST_AWAKE;
        end else if (osc_tick_i || !xtal) begin
          wait_d = wait_q - 11'h001;
        end
      end
      default: state_d = swif_pkg::ST_AWAKE;
    endcase
  end

  // resetn_i acts identically asleep or awake
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= swif_pkg::ST_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end

  // start-up count, only meaningful in the wake wait
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 11'h000;
    end else begin
      wait_q <= wait_d;
    end
  end

  // control bundle leaves reset with the core clock running
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q <= `SWIF_CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // resume pulse on the cycle the core clock comes back
  wire resume_d = (state_q == swif_pkg::ST_WAKE_WAIT) & (state_d == swif_pkg::ST_AWAKE);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resume_q <= 1'b0;
    end else begin
      resume_q <= resume_d;
    end
  end

  // no-op marker: sleep seen but the sequencer stayed awake
  wire nop_d = enter & (state_d == swif_pkg::ST_AWAKE);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nop_q <= 1'b0;
    end else begin
      nop_q <= nop_d;
    end
  end

  // own flop for the sleep pin, so it never comes off a gate
  wire sleep_d = (state_d != swif_pkg::ST_AWAKE);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  // sleep accepted, and a watchdog expiry while asleep
  wire accept = enter & (state_d == swif_pkg::ST_SLEEP);
  wire wdt_wake = (state_q == swif_pkg::ST_SLEEP) & wdt_timeout_i;

  // power-down bit: power-on reset sets it, sleep entry clears it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pd_q <= `SWIF_STATUS_RST;
    end else if (accept) begin
      pd_q <= 1'b0;
    end
  end

  // time-out bit: set on entry, cleared when the watchdog wakes the core
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      to_q <= `SWIF_STATUS_RST;
    end else if (accept) begin
      to_q <= 1'b1;
    end else if (wdt_wake) begin
      to_q <= 1'b0;
    end
  end

  // first flag register follows its next value every cycle
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags1_q <= `SWIF_RST_BYTE;
    end else begin
      flags1_q <= flags1_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags2_q <= `SWIF_RST_BYTE;
    end else begin
      flags2_q <= flags2_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags3_q <= `SWIF_RST_BYTE;
    end else begin
      flags3_q <= flags3_d;
    end
  end

  // interrupt control: global and peripheral enables plus plain bits
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      intctl_q <= `SWIF_RST_BYTE;
    end else if (wric) begin
      intctl_q <= wdat;
    end
  end

  // first enable register, all bits writable
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ena1_q <= `SWIF_RST_BYTE;
    end else if (wre1) begin
      ena1_q <= wdat;
    end
  end

  // second enable register, unimplemented bit stays zero
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ena2_q <= `SWIF_RST_BYTE;
    end else if (wre2) begin
      ena2_q <= wdat & `SWIF_MASK2;
    end
  end

  // third enable register, top bit stays zero
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ena3_q <= `SWIF_RST_BYTE;
    end else if (wre3) begin
      ena3_q <= wdat & `SWIF_MASK3;
    end
  end

  // power control: only regulator, crystal and two-speed bits are kept
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwrctl_q <= `SWIF_RST_BYTE;
    end else if (wrpc) begin
      pwrctl_q <= wdat & `SWIF_PWRCTL_MASK;
    end
  end

  // option register is plain storage, nothing here decodes it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      option_q <= `SWIF_RST_BYTE;
    end else if (wrop) begin
      option_q <= wdat;
    end
  end

  // read mux, unmapped reads zero
  logic [7:0] rd;
  always_comb begin
    case (wb_adr_i)
      8'(`SWIF_OFF_FLAGS1): rd = flags1_q;
      8'(`SWIF_OFF_FLAGS2): rd = flags2_q;
      8'(`SWIF_OFF_FLAGS3): rd = flags3_q;
      8'(`SWIF_OFF_INTCTL): rd = intctl_q;
      8'(`SWIF_OFF_ENA1): rd = ena1_q;
      8'(`SWIF_OFF_ENA2): rd = ena2_q;
      8'(`SWIF_OFF_ENA3): rd = ena3_q;
      8'(`SWIF_OFF_PWRCTL): rd = pwrctl_q;
      8'(`SWIF_OFF_STATUS): rd = {6'h00, to_q, pd_q};
      8'(`SWIF_OFF_OPTION): rd = option_q;
      default: rd = 8'h00;
    endcase
  end

  // one wait state slave, ack drops the cycle after
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // read data stands only with ack, zero otherwise
  wire [31:0] dat_d = req ? {24'h000000, rd} : 32'h00000000;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dat_q <= 32'h00000000;
    end else begin
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign cpu_clk_en_o = ctl_q.cpu_clk_en;
  assign wdt_clear_o = ctl_q.clear_wdt;
  assign regulator_lp_o = ctl_q.regulator_lp;
  assign vector_isr_o = ctl_q.vector_isr;
  assign resume_o = resume_q;
  assign sleep_nop_o = nop_q;
  assign power_down_status_o = pd_q;
  assign timeout_status_o = to_q;
  // only the cpu clock is gated; slow clocks, converter, pins untouched
  assign sleep_active_o = sleep_q;
endmodule

/* common/swif_defs.svh */
// Behaviour
// - flags set on event regardless of enables
// - first flag register layout, rx/tx read-only
// - second flag register layout, bit4 zero
// - third flag register layout, bit7 zero
// - sleep entered only by sleep instruction
// - watchdog cleared on sleep entry
// - entry clears power-down, sets time-out
// - processor clock stopped in sleep
// - low-frequency oscillator keeps running
// - timer1 runs on slow sources
// - converter runs on private oscillator
// - port pins hold drive state
// - non-watchdog resets act as awake
// - reset sources reset, others continue
// - next instruction prefetched during sleep
// - enabled source wakes regardless of global
// - global enable selects vector or in-line
// - watchdog cleared on every wake
// - pending interrupt makes sleep a no-op; here only with global enable clear, else sleep is entered and wakes at once
// - late interrupt completes sleep, wakes
// - crystal wake waits 1024 oscillator periods; here only with two-speed clear, else no crystal wait
// - low-power regulator during sleep when selected
// - low-power sleep adds wake delay; here only without the crystal wait, which replaces it
`ifndef SWIF_DEFS_SVH
`define SWIF_DEFS_SVH
`define SWIF_OFF_FLAGS1 4'h0
`define SWIF_OFF_FLAGS2 4'h4
`define SWIF_OFF_FLAGS3 4'h8
`define SWIF_OFF_INTCTL 4'hc
`define SWIF_OFF_ENA1 5'h10
`define SWIF_OFF_ENA2 5'h14
`define SWIF_OFF_ENA3 5'h18
`define SWIF_OFF_PWRCTL 5'h1c
`define SWIF_OFF_STATUS 6'h20
`define SWIF_OFF_OPTION 6'h24
`define SWIF_MASK1 8'hff
`define SWIF_MASK2 8'hef
`define SWIF_MASK3 8'h7f
`define SWIF_SW_RO1 8'h30
`define SWIF_RST_BYTE 8'h00
`define SWIF_BIT_GIE 7
`define SWIF_BIT_PERIPHERAL_IRQ_ENABLE 6
`define SWIF_BIT_REGULATOR_POWER_MODE_SEL 0
`define SWIF_BIT_XTAL 1
`define SWIF_BIT_TWOSPD 2
`define SWIF_OST_PERIODS 1024
`define SWIF_LP_SETTLE_CYC 16
`define SWIF_CTL_RST 4'h4
`define SWIF_STATUS_RST 1'h1
`define SWIF_PWRCTL_MASK 8'h07
`endif

/* common/swif_pkg.sv */
package swif_pkg;
  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_SLEEP,
    ST_WAKE_WAIT
  } swif_state_t;
  typedef struct packed {
    logic clear_wdt;
    logic cpu_clk_en;
    logic regulator_lp;
    logic vector_isr;
  } swif_ctl_t;
endpackage

/* verification/swif_chk.sv */
module swif_chk (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic sleep_exec_i,
  input wire logic cpu_clk_en_o,
  input wire logic wdt_clear_o,
  input wire logic sleep_active_o,
  input wire logic regulator_lp_o,
  input wire logic resume_o,
  input wire logic sleep_nop_o,
  input wire logic power_down_status_o,
  input wire logic timeout_status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // accepted sleep: clock is running, then drops
  sequence s_sleep_in;
    sleep_exec_i && cpu_clk_en_o ##1 !cpu_clk_en_o;
  endsequence
  a_sleep_cause: assert property ($fell(cpu_clk_en_o) |-> $past(sleep_exec_i))
    else $error("clock stopped with no sleep request");
  a_entry_wdt: assert property (s_sleep_in |-> wdt_clear_o)
    else $error("watchdog not cleared on entry");
  a_entry_stat: assert property (s_sleep_in |-> !power_down_status_o && timeout_status_o)
    else $error("status bits wrong on entry");
  a_clk_gated: assert property (sleep_active_o |-> !cpu_clk_en_o)
    else $error("core clock runs in sleep");
  a_nop_keep: assert property (sleep_nop_o |-> cpu_clk_en_o && $stable(power_down_status_o))
    else $error("no-op sleep changed state");
  a_resume_next: assert property ($rose(cpu_clk_en_o) |-> ##[0:1] resume_o)
    else $error("no resume after wake");
  a_wake_wdt: assert property ($rose(cpu_clk_en_o) |-> $past(wdt_clear_o))
    else $error("watchdog not cleared on wake");
  a_lp_sleep: assert property (regulator_lp_o |-> sleep_active_o)
    else $error("regulator low power while awake");
endmodule

/* verification/swif_core_model.sv */
module swif_core_model (
  input wire logic ref_clk_i,
  output logic sleep_o,
  output logic [7:0] evt1_o,
  output logic [7:0] evt2_o,
  output logic [7:0] evt3_o,
  output logic ext_irq_o,
  output logic wdt_timeout_o,
  output logic osc_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q = 2'h0;
  initial {sleep_o, evt1_o, evt2_o, evt3_o, ext_irq_o, wdt_timeout_o, osc_tick_o} = '0;
  // crystal ticks one per four core clocks, so its wait is visibly longer
  always @(posedge ref_clk_i) begin
    div_q <= div_q + 2'h1;
    osc_tick_o <= (div_q == 2'h3);
  end
  task automatic exec_sleep();
    @(posedge ref_clk_i);
    sleep_o <= 1'b1;
    @(posedge ref_clk_i);
    sleep_o <= 1'b0;
  endtask
  // one-cycle watchdog expiry or external interrupt
  task automatic pulse_wake(input logic w, input logic x);
    @(posedge ref_clk_i);
    {wdt_timeout_o, ext_irq_o} <= {w, x};
    @(posedge ref_clk_i);
    {wdt_timeout_o, ext_irq_o} <= 2'h0;
  endtask
  // one-cycle peripheral events
  task automatic pulse(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge ref_clk_i);
    {evt1_o, evt2_o, evt3_o} <= {a, b, c};
    @(posedge ref_clk_i);
    {evt1_o, evt2_o, evt3_o} <= '0;
  endtask
endmodule

/* verification/sleep_wake_interrupt_flags_tb_top.sv */
module sleep_wake_interrupt_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC_STARTUP_TIMER = 8;
  localparam int LP = 2;
  logic ref_clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, v;
  logic [7:0] wb_adr_i, evt1_i, evt2_i, evt3_i, q;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic ext_irq_i, wdt_timeout_i, sleep_exec_i, osc_tick_i, cpu_clk_en_o, wdt_clear_o;
  logic sleep_active_o, regulator_lp_o, resume_o, vector_isr_o, sleep_nop_o;
  logic power_down_status_o, timeout_status_o;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  swif_top #(.OST_CYCLES(OSC_STARTUP_TIMER), .LP_CYCLES(LP)) dut_u (.*);
  swif_core_model core_u (.ref_clk_i(ref_clk_i), .sleep_o(sleep_exec_i), .evt1_o(evt1_i),
    .evt2_o(evt2_i), .evt3_o(evt3_i), .ext_irq_o(ext_irq_i), .wdt_timeout_o(wdt_timeout_i),
    .osc_tick_o(osc_tick_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // classic cycle, request held until ack is seen at an edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k = 0;
    @(posedge ref_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'h3, we, a, 4'h1};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(8'h00, 8'h01);
      wrap_up();
    end
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  // bounded wait for resume, noting any vector request
  task automatic wait_wake();
    v = 1'b0;
    n = 0;
    while (resume_o !== 1'b1 && n < 400) begin
      @(posedge ref_clk_i);
      n++;
      if (vector_isr_o === 1'b1) v = 1'b1;
    end
    chk(8'(n < 400), 8'h01);
    if (n >= 400) wrap_up();
  endtask
  task automatic t_regs();
    logic [7:0] adr [3] = '{8'h00, 8'h04, 8'h08};
    logic [7:0] msk [3] = '{8'hcf, 8'hef, 8'h7f};
    for (int i = 0; i < 3; i++) begin
      bus(0, adr[i], 8'h00);
      chk(q, 8'h00);
      bus(1, adr[i], 8'hff);
      bus(0, adr[i], 8'h00);
      chk(q, msk[i]);
      bus(1, adr[i], 8'h00);
    end
    bus(1, 8'h3c, 8'hff);
    bus(0, 8'h3c, 8'h00);
    chk(q, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_events();
    core_u.pulse(8'hb1, 8'hff, 8'hff);
    bus(0, 8'h00, 8'h00);
    chk(q, 8'hb1);
    bus(0, 8'h04, 8'h00);
    chk(q, 8'hef);
    bus(1, 8'h00, 8'h00);
    bus(0, 8'h00, 8'h00);
    chk(q, 8'h30);
    bus(1, 8'h04, 8'h00);
    bus(1, 8'h08, 8'h00);
    $display("test events done");
  endtask
  task automatic t_sleep_irq();
    bus(1, 8'h18, 8'h01);
    bus(1, 8'h0c, 8'h40);
    core_u.exec_sleep();
    repeat (3) @(negedge ref_clk_i);
    chk({7'h0, cpu_clk_en_o}, 8'h00);
    bus(0, 8'h20, 8'h00);
    chk(q, 8'h02);
    core_u.pulse(8'h00, 8'h00, 8'h01);
    wait_wake();
    chk({7'h0, v}, 8'h00);
    chk(8'(n < 4 * (OSC_STARTUP_TIMER - 1)), 8'h01);
    $display("test sleep wake done");
  endtask
  task automatic t_sleep_nop();
    v = 1'b0;
    core_u.exec_sleep();
    repeat (3) begin
      @(negedge ref_clk_i);
      if (sleep_nop_o === 1'b1) v = 1'b1;
    end
    chk({7'h0, v}, 8'h01);
    chk({7'h0, cpu_clk_en_o}, 8'h01);
    bus(0, 8'h20, 8'h00);
    chk(q, 8'h02);
    $display("test sleep nop done");
  endtask
  task automatic t_vector();
    // flag cleared before the global enable is set
    bus(1, 8'h08, 8'h00);
    bus(1, 8'h1c, 8'h03);
    bus(1, 8'h0c, 8'hc0);
    core_u.exec_sleep();
    repeat (3) @(negedge ref_clk_i);
    chk({7'h0, regulator_lp_o}, 8'h01);
    core_u.pulse(8'h00, 8'h00, 8'h01);
    wait_wake();
    chk({7'h0, v}, 8'h01);
    chk(8'(n >= 4 * (OSC_STARTUP_TIMER - 1)), 8'h01);
    $display("test vector done");
  endtask
  task automatic t_wdt_wake();
    bus(1, 8'h08, 8'h00);
    bus(1, 8'h1c, 8'h01);
    core_u.exec_sleep();
    repeat (3) @(negedge ref_clk_i);
    core_u.pulse_wake(1'b1, 1'b0);
    wait_wake();
    chk({7'h0, v}, 8'h00);
    chk(8'(n), 8'(2 + LP));
    bus(0, 8'h20, 8'h00);
    chk(q, 8'h00);
    bus(1, 8'h1c, 8'h00);
    core_u.exec_sleep();
    repeat (3) @(negedge ref_clk_i);
    core_u.pulse_wake(1'b0, 1'b1);
    wait_wake();
    chk({7'h0, v}, 8'h00);
    chk(8'(n), 8'h02);
    bus(0, 8'h20, 8'h00);
    chk(q, 8'h02);
    $display("test watchdog wake done");
  endtask
  task automatic t_reset();
    core_u.exec_sleep();
    repeat (3) @(negedge ref_clk_i);
    chk({7'h0, cpu_clk_en_o}, 8'h00);
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(negedge ref_clk_i);
    chk({7'h0, cpu_clk_en_o}, 8'h01);
    bus(0, 8'h20, 8'h00);
    chk(q, 8'h03);
    bus(0, 8'h00, 8'h00);
    chk(q, 8'h00);
    $display("test reset in sleep done");
  endtask
  // main sequence
  initial begin
    {resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_events();
    t_sleep_irq();
    t_sleep_nop();
    t_vector();
    t_wdt_wake();
    t_reset();
    wrap_up();
  end
endmodule
bind swif_top swif_chk chk_u (.*);
